// ==== include/dlerr_defines.vh ====
// Purpose: constants for the die link initiator error control block
// Assumes: one bus clock, AXI4-Lite register access, 32-bit data
// Notes: register byte address is four times the register index
//
// Contract
// (R1) ctrl-one bit 7 enables target interrupt forwarding
// (R2) count link cycles after last; limit expiry flags timeout
// (R3) limit zero: ack only in next cycle
// (R4) nonzero limit: up to limit waits allowed
// (R5) wait limit write-once unless special mode
// (R6) summary flag bit 7 on any error, unmaskable
// (R7) write 1 clears summary, 0 ignored
// (R8) ack cycle not all ones sets bit 6
// (R9) pending summary cancels request, idle, sets bit 5
// (R10) timeout sets status bit 4
// (R11) target error in ack cycle sets bit 3
// (R12) parity error sets status bit 2
// (R13) received parity bits at bits 1 and 0
// (R14) detail flags clear with summary clear
// (R15) link clock is bus clock divided 1 to 4; the code holds the pin low at divide-by-1
// (R16) link enable write-once unless special mode
// (R17) wait counter restarts at last, stops on ack
// (R18) summary sets with detail; details held until cleared
`ifndef DLERR_DEFINES_VH
`define DLERR_DEFINES_VH

// ==========================================================
// register indices
`define DLERR_IDX_CTL0 4'h0
`define DLERR_IDX_CTL1 4'h1
`define DLERR_IDX_STAT 4'h2
`define DLERR_IDX_IRQ_STAT 4'h8
`define DLERR_IDX_IRQ_MASK 4'h9

// ==========================================================
// field positions
`define DLERR_CTL0_ENABLE 7
`define DLERR_CTL1_IRQ_EN 7
`define DLERR_ST_SUMMARY 7
`define DLERR_ST_ACKLINE 6
`define DLERR_ST_CANCEL 5
`define DLERR_ST_TIMEOUT 4
`define DLERR_ST_TARGET 3
`define DLERR_ST_PARITY 2
`define DLERR_IRQ_ERROR 0
`define DLERR_IRQ_EXT 1

// ==========================================================
// reset values and answers
`define DLERR_RST_BYTE 8'h00
`define DLERR_RST_LIMIT 4'h0
`define DLERR_RST_DIV 2'h0
`define DLERR_RESP_OKAY 2'b00
`define DLERR_RESP_SLVERR 2'b10

`endif

// ==== hw/dlerr_clkdiv.v ====
// Purpose: interface clock divider, bus clock over 1 to 4
// Assumes: divider field stable while enabled
// Notes: high phase never longer than low phase
`include "dlerr_defines.vh"

module dlerr_clkdiv (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // control
    input wire enable,
    input wire [1:0] div_sel,
    // link clock
    output reg link_clock_out,
    output reg link_tick
);

    reg [1:0] phase;

    // =====================================================
    // divider: period is div_sel+1 bus cycles
    // high for floor(period/2) cycles; divide-by-1 cannot be
    // built from flops, so the pin stays low, tick every cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            phase <= 2'h0;
            link_clock_out <= 1'b0;
            link_tick <= 1'b0;
        end else if (!enable) begin
            phase <= 2'h0;
            link_clock_out <= 1'b0;
            link_tick <= 1'b0;
        end else begin
            link_tick <= (phase == div_sel); // (R15)
            if (phase == div_sel) begin
                phase <= 2'h0;
            end else begin
                phase <= phase + 2'h1;
            end
            link_clock_out <= (div_sel != 2'h0) &&
                ({1'b0, phase} < ({1'b0, div_sel} + 3'h1) / 3'h2);
        end
    end

endmodule // dlerr_clkdiv

// ==== hw/dlerr_top.v ====
// Purpose: error detection, ack timeout and status of the link initiator
// Assumes: sequencer pulses last and ack strobes on link ticks
// Notes: registers reached over AXI4-Lite, one byte per word
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`include "dlerr_defines.vh"

module dlerr_top #(
    parameter ADDR_W = 6,
    parameter DATA_W = 8
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // mode strap
    input wire special_mode,
    // transaction sequencer side
    input wire txn_req,
    input wire txn_last,
    output wire txn_grant,
    output wire txn_cancel,
    output wire link_cmd_idle,
    // acknowledge cycle sampling
    input wire ack_strobe,
    input wire [DATA_W-1:0] link_data_in,
    input wire target_err_in,
    input wire parity_err_in,
    input wire [1:0] rx_parity,
    // target interrupt request
    input wire ext_irq_in,
    output wire ext_irq_out,
    // link clock
    output wire link_clock_out,
    output wire link_tick,
    output wire link_enable_out,
    // interrupt and status
    output wire irq,
    output wire error_pending
);

    // =====================================================
    // state
    reg link_enable;
    reg [1:0] link_clock_divider;
    reg ext_irq_enable;
    reg [3:0] ack_wait_limit;
    reg error_summary_flag;
    reg ack_line_error_flag;
    reg cancel_flag;
    reg timeout_error_flag;
    reg target_error_flag;
    reg parity_error_flag;
    reg rx_parity_upper;
    reg rx_parity_lower;
    reg waiting;
    reg [3:0] wait_count;
    reg [1:0] irq_status;
    reg [1:0] irq_mask;
    reg ext_irq_seen;
    reg aw_held;
    reg w_held;
    reg [ADDR_W-1:0] aw_addr;
    reg [7:0] w_byte;
    reg w_lane0;

    // =====================================================
    // helpers
    function [3:0] reg_index;
        input [ADDR_W-1:0] addr;
        begin
            reg_index = addr[5:2];
        end
    endfunction

    function mapped;
        input [3:0] idx;
        begin
            mapped = (idx == `DLERR_IDX_CTL0) ||
                     (idx == `DLERR_IDX_CTL1) ||
                     (idx == `DLERR_IDX_STAT) ||
                     (idx == `DLERR_IDX_IRQ_STAT) ||
                     (idx == `DLERR_IDX_IRQ_MASK);
        end
    endfunction

    // =====================================================
    // interface clock
    dlerr_clkdiv u_clkdiv (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(link_enable),
        .div_sel(link_clock_divider),
        .link_clock_out(link_clock_out),
        .link_tick(link_tick)
    );

    // =====================================================
    // write channel: address and data taken in either order
    wire do_write;
    wire [3:0] wr_idx;
    wire wr_ok;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_idx = reg_index(aw_addr);
    assign wr_ok = do_write && w_lane0;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= {ADDR_W{1'b0}};
            w_byte <= `DLERR_RST_BYTE;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DLERR_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(wr_idx) ? `DLERR_RESP_OKAY
                                              : `DLERR_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // =====================================================
    // control registers; write-once guards once enabled
    wire ctl_locked;
    assign ctl_locked = link_enable && !special_mode;

    always @(posedge aclk) begin
        if (!aresetn) begin
            link_enable <= 1'b0;
            link_clock_divider <= `DLERR_RST_DIV;
            ext_irq_enable <= 1'b0;
            ack_wait_limit <= `DLERR_RST_LIMIT;
            irq_mask <= 2'h0;
        end else if (wr_ok) begin
            if (wr_idx == `DLERR_IDX_CTL0 && !ctl_locked) begin
                link_enable <= w_byte[`DLERR_CTL0_ENABLE]; // (R16)
                link_clock_divider <= w_byte[1:0]; // (R15)
            end
            if (wr_idx == `DLERR_IDX_CTL1) begin
                ext_irq_enable <= w_byte[`DLERR_CTL1_IRQ_EN]; // (R1)
                if (!ctl_locked) begin
                    ack_wait_limit <= w_byte[3:0]; // (R5)
                end
            end
            if (wr_idx == `DLERR_IDX_IRQ_MASK) begin
                irq_mask <= w_byte[1:0];
            end
        end
    end

    // =====================================================
    // request gate: a pending error turns a request into idle
    assign txn_grant = txn_req && link_enable && !error_summary_flag;
    assign txn_cancel = txn_req && link_enable && error_summary_flag; // (R9)
    assign link_cmd_idle = !txn_grant; // (R9)
    assign ext_irq_out = ext_irq_in && ext_irq_enable; // (R1)
    assign link_enable_out = link_enable;

    // =====================================================
    // acknowledge wait counter, advanced on link ticks only
    wire ack_now;
    wire expire;
    assign ack_now = waiting && link_tick && ack_strobe;
    // limit zero: no ack on the first tick is already late
    assign expire = waiting && link_tick && !ack_strobe &&
                    (wait_count == ack_wait_limit); // (R2) (R3) (R4)

    always @(posedge aclk) begin
        if (!aresetn) begin
            waiting <= 1'b0;
            wait_count <= 4'h0;
        end else if (txn_last) begin
            waiting <= 1'b1; // (R17)
            wait_count <= 4'h0; // (R17)
        end else if (ack_now || expire) begin
            waiting <= 1'b0; // (R17)
        end else if (waiting && link_tick) begin
            wait_count <= wait_count + 4'h1; // (R4)
        end
    end

    // =====================================================
    // error flags: a new error wins over a same-cycle clear
    wire clr_errors;
    wire set_ackline;
    wire set_cancel;
    wire set_timeout;
    wire set_target;
    wire set_parity;
    wire any_set;
    assign clr_errors = wr_ok && (wr_idx == `DLERR_IDX_STAT) &&
                        w_byte[`DLERR_ST_SUMMARY]; // (R7)
    assign set_ackline = ack_now && !(&link_data_in); // (R8)
    assign set_cancel = txn_cancel; // (R9)
    assign set_timeout = expire; // (R10)
    assign set_target = ack_now && target_err_in; // (R11)
    assign set_parity = parity_err_in; // (R12)
    assign any_set = set_ackline || set_cancel || set_timeout ||
                     set_target || set_parity;

    always @(posedge aclk) begin
        if (!aresetn) begin
            error_summary_flag <= 1'b0;
            ack_line_error_flag <= 1'b0;
            cancel_flag <= 1'b0;
            timeout_error_flag <= 1'b0;
            target_error_flag <= 1'b0;
            parity_error_flag <= 1'b0;
        end else begin
            // summary follows any detail in the same cycle
            error_summary_flag <= any_set ||
                (error_summary_flag && !clr_errors); // (R6) (R18)
            ack_line_error_flag <= set_ackline ||
                (ack_line_error_flag && !clr_errors); // (R14) (R18)
            cancel_flag <= set_cancel ||
                (cancel_flag && !clr_errors); // (R14)
            timeout_error_flag <= set_timeout ||
                (timeout_error_flag && !clr_errors); // (R14)
            target_error_flag <= set_target ||
                (target_error_flag && !clr_errors); // (R14)
            parity_error_flag <= set_parity ||
                (parity_error_flag && !clr_errors); // (R14)
        end
    end

    // =====================================================
    // received parity bits, updated on each ack or parity event
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_parity_upper <= 1'b0;
            rx_parity_lower <= 1'b0;
        end else if (ack_now || parity_err_in) begin
            rx_parity_upper <= rx_parity[1]; // (R13)
            rx_parity_lower <= rx_parity[0]; // (R13)
        end
    end

    // =====================================================
    // read channel; one outstanding read at a time
    wire [3:0] rd_idx;
    wire rd_take;
    wire [7:0] stat_byte;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign rd_idx = reg_index(s_axi_araddr);
    assign stat_byte = {error_summary_flag, ack_line_error_flag,
                        cancel_flag, timeout_error_flag,
                        target_error_flag, parity_error_flag,
                        rx_parity_upper, rx_parity_lower};

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DLERR_RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(rd_idx) ? `DLERR_RESP_OKAY
                                          : `DLERR_RESP_SLVERR;
            case (rd_idx)
                `DLERR_IDX_CTL0: begin
                    s_axi_rdata <= {24'h00_0000, link_enable, 5'h00,
                                    link_clock_divider};
                end
                `DLERR_IDX_CTL1: begin
                    s_axi_rdata <= {24'h00_0000, ext_irq_enable, 3'h0,
                                    ack_wait_limit};
                end
                `DLERR_IDX_STAT: begin
                    s_axi_rdata <= {24'h00_0000, stat_byte};
                end
                `DLERR_IDX_IRQ_STAT: begin
                    s_axi_rdata <= {30'h0000_0000, irq_status};
                end
                `DLERR_IDX_IRQ_MASK: begin
                    s_axi_rdata <= {30'h0000_0000, irq_mask};
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // =====================================================
    // sticky interrupt status, cleared by its read; an event in
    // the read cycle survives so no edge is lost
    wire irq_rd_clr;
    wire ext_rise;
    assign irq_rd_clr = rd_take && (rd_idx == `DLERR_IDX_IRQ_STAT);
    assign ext_rise = ext_irq_out && !ext_irq_seen;

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= 2'h0;
            ext_irq_seen <= 1'b0;
        end else begin
            ext_irq_seen <= ext_irq_out;
            irq_status[`DLERR_IRQ_ERROR] <= any_set ||
                (irq_status[`DLERR_IRQ_ERROR] && !irq_rd_clr);
            irq_status[`DLERR_IRQ_EXT] <= ext_rise ||
                (irq_status[`DLERR_IRQ_EXT] && !irq_rd_clr);
        end
    end

    // summary error is never masked, the rest through the mask
    assign irq = |(irq_status & irq_mask) || error_summary_flag; // (R6)
    assign error_pending = error_summary_flag;

endmodule // dlerr_top

// ==== testbench/dlerr_top_chk.sv ====
// Purpose: port-level checks of the link error block
// Assumes: one clock, reset synchronous and active low
// Notes: bound to every dlerr_top instance
module dlerr_top_chk (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // register bus
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    // link side
    input logic special_mode,
    input logic txn_req,
    input logic txn_grant,
    input logic txn_cancel,
    input logic link_cmd_idle,
    input logic parity_err_in,
    input logic ext_irq_in,
    input logic ext_irq_out,
    input logic link_clock_out,
    input logic link_tick,
    input logic link_enable_out,
    // status
    input logic irq,
    input logic error_pending
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // one domain only
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // handshake steps of the register bus
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // ==========
    // checks
    a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_grant_rule: assert property (
        txn_req |-> txn_grant == (link_enable_out && !error_pending))
        else $error("grant wrong");
    a_cancel_idle: assert property (
        txn_cancel |-> error_pending && link_cmd_idle && !txn_grant)
        else $error("cancel without idle");
    a_summary_irq: assert property (error_pending |-> irq)
        else $error("summary not on irq");
    a_summary_clear: assert property (
        $fell(error_pending) |-> $rose(s_axi_bvalid))
        else $error("summary cleared without write");
    a_error_cause: assert property (
        $rose(error_pending) |-> $past(link_tick) || $past(parity_err_in))
        else $error("summary without cause");
    a_parity_sets: assert property (parity_err_in |=> error_pending)
        else $error("parity error lost");
    a_ext_gate: assert property (ext_irq_out |-> ext_irq_in)
        else $error("ext irq without request");
    a_clock_high: assert property (
        $rose(link_clock_out) |-> ##[1:2] !link_clock_out)
        else $error("link clock high too long");
    a_enable_once: assert property (
        $fell(link_enable_out) |-> $past(special_mode))
        else $error("link disabled in normal mode");
endmodule // dlerr_top_chk

bind dlerr_top dlerr_top_chk u_chk (.*);

// ==== testbench/dlerr_target_model.sv ====
// Purpose: behavioural target die answering link transactions
// Assumes: wait states counted in link ticks after txn_last
// Notes: lines toggle outside ack so stale values never pass
module dlerr_target_model (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // link side
    input logic link_tick,
    input logic txn_last,
    output logic ack_strobe,
    output logic [7:0] link_data_in,
    output logic target_err_in,
    output logic [1:0] rx_parity,
    // scenario controls
    input logic [4:0] wait_n,
    input logic bad_line,
    input logic fail,
    input logic [1:0] par,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt;
    logic noise;
    // ack once the asked wait states are spent
    assign ack_strobe = busy && cnt == wait_n;
    assign link_data_in = ack_strobe ? {bad_line ? 8'h7f : 8'hff} : {8{noise}};
    assign target_err_in = ack_strobe ? fail : noise;
    assign rx_parity = par;
    // wait counter, restarted by every last transfer
    always @(posedge aclk) begin
        if (!aresetn) begin
            busy <= 1'b0;
            cnt <= 5'h00;
            noise <= 1'b0;
        end else begin
            noise <= ~noise;
            if (txn_last) begin
                busy <= 1'b1;
                cnt <= 5'h00;
            end else if (busy && link_tick) begin
                if (ack_strobe)
                    busy <= 1'b0;
                else
                    cnt <= cnt + 5'h01;
            end
        end
    end
endmodule // dlerr_target_model

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench of the link error block
// Assumes: tick every cycle in ack tests to keep waits short
// Notes: a hang is cut short by a cycle ceiling
`include "dlerr_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // signals
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, special_mode, txn_req, txn_last;
    logic parity_err_in, ext_irq_in, bad_line, fail;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic [4:0] wait_n;
    logic [1:0] par;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, txn_grant, txn_cancel, link_cmd_idle, ack_strobe;
    wire target_err_in, ext_irq_out, link_clock_out, link_tick, busy;
    wire link_enable_out, irq, error_pending;
    wire [1:0] s_axi_bresp, s_axi_rresp, rx_parity;
    wire [31:0] s_axi_rdata;
    wire [7:0] link_data_in;
    int n_errors, checked, cyc, h, p;
    localparam logic [1:0] ok = `DLERR_RESP_OKAY;
    localparam logic [1:0] se = `DLERR_RESP_SLVERR;
    localparam logic [3:0] ic0 = `DLERR_IDX_CTL0;
    localparam logic [3:0] ic1 = `DLERR_IDX_CTL1;
    localparam logic [3:0] ist = `DLERR_IDX_STAT;
    localparam logic [3:0] iqs = `DLERR_IDX_IRQ_STAT;
    localparam logic [3:0] iqm = `DLERR_IDX_IRQ_MASK;
    dlerr_top uut (.*);
    dlerr_target_model u_tgt (.*);
    // clock, 8 ns period
    always #4 aclk = ~aclk;
    // cycle ceiling against hangs
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            test_done();
        end
    end
    // ==========
    // tasks
    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic test_done();
        if (n_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // write: address and data offered together, each held until taken
    task automatic wr(input logic [3:0] i, input logic [7:0] d,
                      input logic [1:0] er);
        logic ga, gw, gb;
        logic [1:0] r;
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            #1;
            ga = s_axi_awvalid && s_axi_awready;
            gw = s_axi_wvalid && s_axi_wready;
            gb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ga) s_axi_awvalid <= 1'b0;
            if (gw) s_axi_wvalid <= 1'b0;
        end while (!gb);
        chk("write resp", 32'(er), 32'(r));
    endtask
    task automatic rdc(input string nm, input logic [3:0] i,
                       input logic [31:0] e, input logic [1:0] er);
        logic ga, gr;
        logic [31:0] d;
        logic [1:0] r;
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        do begin
            #1;
            ga = s_axi_arvalid && s_axi_arready;
            gr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ga) s_axi_arvalid <= 1'b0;
        end while (!gr);
        chk(nm, e, d);
        chk("read resp", 32'(er), 32'(r));
    endtask
    // one transaction end, then wait for the target to finish
    task automatic txn(input logic [4:0] w, input logic b, f);
        wait_n <= w;
        bad_line <= b;
        fail <= f;
        txn_last <= 1'b1;
        @(posedge aclk);
        txn_last <= 1'b0;
        for (int k = 0; k < 40; k++) begin
            @(posedge aclk);
            #1;
            if (!busy) break;
        end
        @(posedge aclk);
    endtask
    task automatic tst(input logic [4:0] w, input logic b, f,
                       input logic [7:0] e);
        txn(w, b, f);
        rdc("status", ist, {24'h00_0000, e}, ok);
        wr(ist, 8'h80, ok);
        rdc("status", ist, 32'h0000_0000, ok);
    endtask
    task automatic req(input logic g);
        txn_req <= 1'b1;
        #1;
        chk1("grant", g, txn_grant);
        chk1("cancel", !g, txn_cancel);
        chk1("idle", !g, link_cmd_idle);
        @(posedge aclk);
        txn_req <= 1'b0;
    endtask
    // ==========
    // main sequence
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, special_mode} = 4'h0;
        {txn_req, txn_last, parity_err_in, ext_irq_in} = 4'h0;
        {bad_line, fail, s_axi_bready, s_axi_rready} = 4'h3;
        s_axi_awaddr = 6'h00;
        s_axi_araddr = 6'h00;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        wait_n = 5'h00;
        par = 2'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc("status", ist, 32'h0000_0000, ok);
        rdc("control one", ic1, 32'h0000_0000, ok);
        rdc("unmapped", 4'h3, 32'h0000_0000, se);
        wr(4'h3, 8'hff, se);
        wr(ic1, 8'h82, ok);
        wr(ic0, 8'h80, ok);
        wr(ic1, 8'h05, ok);
        rdc("control one", ic1, 32'h0000_0002, ok);
        wr(ic0, 8'h03, ok);
        rdc("control zero", ic0, 32'h0000_0080, ok);
        req(1'b1);
        tst(5'h02, 1'b0, 1'b0, 8'h00);
        txn(5'h03, 1'b0, 1'b0);
        rdc("status", ist, 32'h0000_0090, ok);
        chk1("irq", 1'b1, irq);
        chk1("pending", 1'b1, error_pending);
        req(1'b0);
        wr(ist, 8'h00, ok);
        rdc("status", ist, 32'h0000_00b0, ok);
        rdc("irq status", iqs, 32'h0000_0001, ok);
        rdc("irq status", iqs, 32'h0000_0000, ok);
        wr(ist, 8'h80, ok);
        rdc("status", ist, 32'h0000_0000, ok);
        special_mode <= 1'b1;
        wr(ic1, 8'h80, ok);
        tst(5'h00, 1'b0, 1'b0, 8'h00);
        tst(5'h01, 1'b0, 1'b0, 8'h90);
        tst(5'h00, 1'b1, 1'b0, 8'hc0);
        tst(5'h00, 1'b0, 1'b1, 8'h88);
        par <= 2'h2;
        parity_err_in <= 1'b1;
        @(posedge aclk);
        parity_err_in <= 1'b0;
        rdc("status", ist, 32'h0000_0086, ok);
        wr(ist, 8'h80, ok);
        rdc("status", ist, 32'h0000_0002, ok);
        chk1("pending", 1'b0, error_pending);
        rdc("irq status", iqs, 32'h0000_0001, ok);
        ext_irq_in <= 1'b1;
        @(posedge aclk);
        #1;
        chk1("ext irq", 1'b1, ext_irq_out);
        chk1("irq", 1'b0, irq);
        @(posedge aclk);
        wr(iqm, 8'h02, ok);
        chk1("irq", 1'b1, irq);
        rdc("irq status", iqs, 32'h0000_0002, ok);
        chk1("irq", 1'b0, irq);
        wr(ic1, 8'h00, ok);
        chk1("ext irq", 1'b0, ext_irq_out);
        // lane 0 not strobed: write answered, register untouched
        s_axi_wstrb <= 4'he;
        wr(ic1, 8'h8f, ok);
        s_axi_wstrb <= 4'hf;
        rdc("control one", ic1, 32'h0000_0000, ok);
        // every divider code: tick spacing and high phase
        for (int d = 0; d < 4; d++) begin
            wr(ic0, 8'h80 | 8'(d), ok);
            h = 0;
            p = 0;
            do begin
                @(posedge aclk);
                #1;
            end while (!link_tick);
            do begin
                @(posedge aclk);
                #1;
                p++;
                h += int'(link_clock_out);
            end while (!link_tick);
            chk("tick period", 32'(d + 1), 32'(p));
            chk("clock high", 32'((d + 1) / 2), 32'(h));
            @(posedge aclk);
        end
        wr(ic0, 8'h00, ok);
        chk1("link enable", 1'b0, link_enable_out);
        test_done();
    end
endmodule // testbench
